// File: hw/adc_pkg.sv
// Constants shared by the antenna driver control block.
// Assumes a 40 MHz system clock and a 13.56 MHz carrier reference.
package adc_pkg;

	// ==========================================================
	// Register map (byte offsets on the plain register port)
	localparam logic [7:0] ADC_OFS_DRV_CTRL = 8'h14;
	localparam logic [7:0] ADC_OFS_AUTO_CTRL = 8'h15;
	localparam logic [7:0] ADC_OFS_RX_MODE = 8'h1C;
	localparam logic [7:0] ADC_OFS_STATUS = 8'h1D;

	// Reset values
	localparam logic [7:0] ADC_RST_DRV_CTRL = 8'h80;
	localparam logic [7:0] ADC_RST_AUTO_CTRL = 8'h00;
	localparam logic [7:0] ADC_RST_RX_MODE = 8'h00;

	// ==========================================================
	// Driver control field positions
	localparam int ADC_B_INV2_ON = 7;
	localparam int ADC_B_INV1_ON = 6;
	localparam int ADC_B_INV2_OFF = 5;
	localparam int ADC_B_INV1_OFF = 4;
	localparam int ADC_B_CW2 = 3;
	localparam int ADC_B_CHECK = 2;
	localparam int ADC_B_EN2 = 1;
	localparam int ADC_B_EN1 = 0;
	// Readable bits (field check is write-only)
	localparam logic [7:0] ADC_MSK_DRV_CTRL = 8'hFB;

	// Auto control field positions
	localparam int ADC_B_AUTO_OFF = 7;
	localparam int ADC_B_FULL_ASK = 6;
	localparam int ADC_B_WAKE = 5;
	localparam int ADC_B_CA = 3;
	localparam int ADC_B_INIT = 2;
	localparam int ADC_B_AUTO2 = 1;
	localparam int ADC_B_AUTO1 = 0;
	// Bit 4 is reserved and reads zero
	localparam logic [7:0] ADC_MSK_AUTO_CTRL = 8'hEF;

	// Receive framing field
	localparam logic [7:0] ADC_MSK_RX_MODE = 8'h03;
	localparam logic [1:0] ADC_FRM_TYPE_A = 2'h0;
	localparam logic [1:0] ADC_FRM_ACTIVE = 2'h1;
	localparam logic [1:0] ADC_FRM_PASSIVE_HI = 2'h2;
	localparam logic [1:0] ADC_FRM_TYPE_B = 2'h3;

	// Driver source select encodings
	localparam logic [1:0] ADC_SRC_TRISTATE = 2'h0;
	localparam logic [1:0] ADC_SRC_CODER = 2'h1;
	localparam logic [1:0] ADC_SRC_SIGIN = 2'h2;
	localparam logic [1:0] ADC_SRC_HIGH = 2'h3;

	// Modulation depth code meaning full (100 %) ASK
	localparam logic [5:0] ADC_MOD_DEPTH_FULL = 6'h00;

	// ==========================================================
	// Timing, in carrier cycles, converted to system clock cycles
	localparam int ADC_MCLK_KHZ = 40000;
	localparam int ADC_FC_KHZ = 13560;
	localparam int ADC_INITIAL_DELAY_TIME_FC = 4096;
	localparam int ADC_ACTIVE_DELAY_TIME_FC = 768;
	localparam int ADC_TRFW_FC = 512;
	// Least times: round up
	localparam int ADC_INITIAL_DELAY_TIME_CYC =
		(ADC_INITIAL_DELAY_TIME_FC * ADC_MCLK_KHZ + ADC_FC_KHZ - 1) / ADC_FC_KHZ;
	localparam int ADC_ACTIVE_DELAY_TIME_CYC =
		(ADC_ACTIVE_DELAY_TIME_FC * ADC_MCLK_KHZ + ADC_FC_KHZ - 1) / ADC_FC_KHZ;
	localparam int ADC_TRFW_CYC =
		(ADC_TRFW_FC * ADC_MCLK_KHZ + ADC_FC_KHZ - 1) / ADC_FC_KHZ;

	// Auto switch-on sequencer
	typedef enum logic [1:0] {
		ADC_ST_IDLE,
		ADC_ST_INIT_WAIT,
		ADC_ST_FIELD_ON,
		ADC_ST_ADT_WAIT
	} adc_state_t;

endpackage

// File: hw/adc_antenna_driver_control.sv
// Antenna driver control: registers, driver output shaping and the
// automatic switch-on/off sequencing for both antenna drivers.
// Assumes carrier, envelopes and transmit status come from logic on
// i_mclk; the external field indication is asynchronous.
//
// Function
// - Two-bit receive framing field selects type A, active, 212/424 or type B.
// - Control bit 7 inverts second driver output while it is enabled.
// - Control bit 6 inverts first driver output while it is enabled.
// - Control bit 5 inverts second driver output while it is disabled.
// - Control bit 4 inverts first driver output while it is disabled.
// - Continuous-carrier bit makes second driver send unmodulated carrier.
// - Writing field-check as one refuses enabling drivers when a field exists.
// - Control bit 1 makes second driver send carrier modulated by data.
// - Control bit 0 makes first driver send carrier modulated by data.
// - Auto-off bit switches all drivers off after the last sent bit.
// - Force-full-ASK bit applies 100 percent ASK whatever the depth setting.
// - Field-wake bit leaves soft power-down when the level detector fires.
// - Collision-avoid bit activates response avoidance with internal slot n.
// - Initial-avoid bit runs initial avoidance, self-clears once carrier on.
// - Second auto-enable switches driver on active delay after field off.
// - With initial avoid, second driver starts after field-free initial delay.
// - First auto-enable switches driver on active delay after field off.
// - With initial avoid, first driver starts after field-free initial delay.
// - Constant-high source level follows each driver's inversion settings.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module adc_antenna_driver_control
	import adc_pkg::*;
#(
	parameter int INITIAL_DELAY_TIME_CYCLES = ADC_INITIAL_DELAY_TIME_CYC,
	parameter int ACTIVE_DELAY_TIME_CYCLES = ADC_ACTIVE_DELAY_TIME_CYC,
	parameter int TRFW_CYCLES = ADC_TRFW_CYC,
	parameter int CNT_W = 16
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_carrier,
	input wire logic i_coder_env,
	input wire logic i_sigin_env,
	input wire logic [1:0] i_drv_source_select,
	input wire logic [5:0] i_modulation_depth_setting,
	input wire logic i_tx_last_bit_done,
	input wire logic i_ext_field,
	input wire logic i_soft_power_down,
	output logic o_first_antenna_driver,
	output logic o_first_antenna_driver_oe,
	output logic o_second_antenna_driver,
	output logic o_second_antenna_driver_oe,
	output logic [5:0] o_mod_depth,
	output logic o_field_wake,
	output logic [1:0] o_rx_frame_format,
	output logic o_collision_avoid_enable,
	output logic [1:0] o_slot_n
);

	// ==========================================================
	// Field detector synchroniser
	logic [2:0] field_sync_q;
	logic field_q;
	logic field_prev_q;
	logic field_fall;
	logic field_rise;

	// Three stages; level accepted once stages two and three agree
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			field_sync_q <= 3'h0;
		else
			field_sync_q <= {field_sync_q[1:0], i_ext_field};
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			field_q <= 1'b0;
			field_prev_q <= 1'b0;
		end
		else
		begin
			if (field_sync_q[1] == field_sync_q[2])
				field_q <= field_sync_q[2];
			field_prev_q <= field_q;
		end
	end

	assign field_fall = field_prev_q && !field_q;
	assign field_rise = !field_prev_q && field_q;

	// ==========================================================
	// Register storage and decode
	logic [7:0] drv_ctrl_q;
	logic [7:0] auto_ctrl_q;
	logic [1:0] rx_frame_q;
	logic wr_drv;
	logic wr_auto;
	logic refuse_en;
	logic [1:0] en_sw;
	logic [1:0] en_set;
	logic [1:0] en_clr;
	logic init_clr;
	adc_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [1:0] slot_q;
	logic [3:0] lfsr_q;

	assign wr_drv = i_wr && (i_addr == ADC_OFS_DRV_CTRL);
	assign wr_auto = i_wr && (i_addr == ADC_OFS_AUTO_CTRL);

	// field check refusal
	// Only setting is refused; clearing an enable always goes through
	assign refuse_en = i_wdata[ADC_B_CHECK] && field_q;

	// Software view of the enable bits after this cycle's write
	always_comb
	begin
		en_sw = drv_ctrl_q[ADC_B_EN2:ADC_B_EN1];
		if (wr_drv)
		begin
			if (refuse_en)
				en_sw = en_sw & i_wdata[ADC_B_EN2:ADC_B_EN1];
			else
				en_sw = i_wdata[ADC_B_EN2:ADC_B_EN1];
		end
	end

	// auto switch-off after the last transmitted bit
	assign en_clr = (auto_ctrl_q[ADC_B_AUTO_OFF] && i_tx_last_bit_done) ?
		2'h3 : 2'h0;

	// Driver control register; hardware set wins over any clear
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			drv_ctrl_q <= ADC_RST_DRV_CTRL;
		else
		begin
			if (wr_drv)
			begin
				drv_ctrl_q[7:ADC_B_CW2] <= i_wdata[7:ADC_B_CW2];
				drv_ctrl_q[ADC_B_CHECK] <= i_wdata[ADC_B_CHECK];
			end
			drv_ctrl_q[ADC_B_EN2:ADC_B_EN1] <= (en_sw & ~en_clr) | en_set;
		end
	end

	// initial avoid bit clears itself when the carrier comes on
	assign init_clr = (state_q == ADC_ST_INIT_WAIT) && (en_set != 2'h0);

	// Auto control register; a software set beats the self-clear
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			auto_ctrl_q <= ADC_RST_AUTO_CTRL;
		else if (wr_auto)
			auto_ctrl_q <= i_wdata & ADC_MSK_AUTO_CTRL;
		else if (init_clr)
			auto_ctrl_q[ADC_B_INIT] <= 1'b0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			rx_frame_q <= ADC_RST_RX_MODE[1:0];
		else if (i_wr && (i_addr == ADC_OFS_RX_MODE))
			rx_frame_q <= i_wdata[1:0];
	end

	// ==========================================================
	// Register read port, data valid the cycle after the strobe
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_rd)
		begin
			case (i_addr)
				ADC_OFS_DRV_CTRL:
					o_rdata <= drv_ctrl_q & ADC_MSK_DRV_CTRL;
				ADC_OFS_AUTO_CTRL:
					o_rdata <= auto_ctrl_q;
				ADC_OFS_RX_MODE:
					o_rdata <= {6'h00, rx_frame_q};
				ADC_OFS_STATUS:
					o_rdata <= {field_q, 1'b0, slot_q, cnt_q != '0,
						1'b0, state_q};
				default:
					o_rdata <= 8'h00;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end

	// ==========================================================
	// Response collision avoidance slot draw
	// A free-running LFSR stands in for a random source; n in 0..3
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			lfsr_q <= 4'h1;
		else
			lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
	end

	// draw n each time the remote field drops
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			slot_q <= 2'h0;
		else if (field_fall && auto_ctrl_q[ADC_B_CA])
			slot_q <= lfsr_q[1:0];
		else if (!auto_ctrl_q[ADC_B_CA])
			slot_q <= 2'h0;
	end

	// ==========================================================
	// Automatic switch-on sequencer
	logic [1:0] auto_en;
	logic [CNT_W-1:0] adt_target;
	logic [CNT_W-1:0] idt_target;

	// only drivers flagged by software are switched on
	assign auto_en = auto_ctrl_q[ADC_B_AUTO2:ADC_B_AUTO1];

	// delay lengths; response avoidance adds n wait slots
	assign idt_target = CNT_W'(INITIAL_DELAY_TIME_CYCLES);
	assign adt_target = CNT_W'(ACTIVE_DELAY_TIME_CYCLES) +
		(auto_ctrl_q[ADC_B_CA] ?
		CNT_W'(slot_q) * CNT_W'(TRFW_CYCLES) : '0);

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			state_q <= ADC_ST_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				ADC_ST_IDLE:
				begin
					cnt_q <= '0;
					// initial avoidance arms at once, whatever the field level
					// same arming for the first driver
					if (auto_ctrl_q[ADC_B_INIT] && auto_en != 2'h0)
						state_q <= ADC_ST_INIT_WAIT;
					else if (auto_en != 2'h0 && field_q)
						state_q <= ADC_ST_FIELD_ON;
				end
				ADC_ST_INIT_WAIT:
				begin
					// Any field sighting restarts the quiet window
					if (!auto_ctrl_q[ADC_B_INIT] || auto_en == 2'h0)
						state_q <= ADC_ST_IDLE;
					else if (field_q)
						cnt_q <= '0;
					else if (cnt_q >= idt_target - 1'b1)
						state_q <= ADC_ST_IDLE;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				ADC_ST_FIELD_ON:
				begin
					cnt_q <= '0;
					if (auto_en == 2'h0)
						state_q <= ADC_ST_IDLE;
					else if (field_fall)
						state_q <= ADC_ST_ADT_WAIT;
				end
				ADC_ST_ADT_WAIT:
				begin
					// wait the active delay after the field drops
					// same delay for the first driver
					// A returning field aborts; the peer still talks
					if (auto_en == 2'h0)
						state_q <= ADC_ST_IDLE;
					else if (field_rise)
						state_q <= ADC_ST_FIELD_ON;
					else if (cnt_q >= adt_target - 1'b1)
						state_q <= ADC_ST_IDLE;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				default:
				begin
					state_q <= ADC_ST_IDLE;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// Switch-on pulse at the end of either delay
	always_comb
	begin
		en_set = 2'h0;
		if (state_q == ADC_ST_INIT_WAIT && auto_ctrl_q[ADC_B_INIT]
			&& !field_q && cnt_q >= idt_target - 1'b1)
			en_set = auto_en;
		else if (state_q == ADC_ST_ADT_WAIT && !field_rise
			&& cnt_q >= adt_target - 1'b1)
			en_set = auto_en;
	end

	// ==========================================================
	// Driver output shaping, one slice per driver
	logic [1:0] drv_en;
	logic [1:0] inv_on;
	logic [1:0] inv_off;
	logic [1:0] cw;
	logic env;
	logic [1:0] drv_d;
	logic drv_oe_d;

	assign drv_en = drv_ctrl_q[ADC_B_EN2:ADC_B_EN1];
	assign inv_on = {drv_ctrl_q[ADC_B_INV2_ON], drv_ctrl_q[ADC_B_INV1_ON]};
	assign inv_off = {drv_ctrl_q[ADC_B_INV2_OFF],
		drv_ctrl_q[ADC_B_INV1_OFF]};
	// continuous carrier applies to the second driver only
	assign cw = {drv_ctrl_q[ADC_B_CW2], 1'b0};

	// Envelope chosen by source select; high gives a steady level
	always_comb
	begin
		case (i_drv_source_select)
			ADC_SRC_CODER:
				env = i_coder_env;
			ADC_SRC_SIGIN:
				env = i_sigin_env;
			// constant high, then shaped by the inversion bits
			ADC_SRC_HIGH:
				env = 1'b1;
			default:
				env = 1'b0;
		endcase
	end

	assign drv_oe_d = (i_drv_source_select != ADC_SRC_TRISTATE);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_drv
			logic raw;
			// enabled second driver sends modulated carrier, or plain carrier when the continuous-carrier bit is set
			// enabled first driver sends modulated carrier
			assign raw = drv_en[g] &&
				(cw[g] ? i_carrier : (i_carrier && env));
			assign drv_d[g] = raw ^ (drv_en[g] ? inv_on[g] : inv_off[g]);
		end
	endgenerate

	// Registered driver pins; one cycle late against the carrier input
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_first_antenna_driver <= 1'b0;
			o_second_antenna_driver <= 1'b0;
			o_first_antenna_driver_oe <= 1'b0;
			o_second_antenna_driver_oe <= 1'b0;
		end
		else
		begin
			o_first_antenna_driver <= drv_d[0];
			o_second_antenna_driver <= drv_d[1];
			o_first_antenna_driver_oe <= drv_oe_d;
			o_second_antenna_driver_oe <= drv_oe_d;
		end
	end

	// ==========================================================
	// Status outputs toward the modulator, receiver and power control
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_mod_depth <= 6'h00;
			o_field_wake <= 1'b0;
			o_rx_frame_format <= ADC_FRM_TYPE_A;
			o_collision_avoid_enable <= 1'b0;
			o_slot_n <= 2'h0;
		end
		else
		begin
			// forced full ASK overrides the depth setting
			o_mod_depth <= auto_ctrl_q[ADC_B_FULL_ASK] ?
				ADC_MOD_DEPTH_FULL : i_modulation_depth_setting;
			// one-cycle wake request on a rising field level
			o_field_wake <= auto_ctrl_q[ADC_B_WAKE] &&
				i_soft_power_down && field_rise;
			o_rx_frame_format <= rx_frame_q;
			// response avoidance active with its slot count
			o_collision_avoid_enable <= auto_ctrl_q[ADC_B_CA];
			o_slot_n <= auto_ctrl_q[ADC_B_CA] ? slot_q : 2'h0;
		end
	end

endmodule

// File: dv/adc_field_model.sv
// Far-side model: remote field source and carrier reference.
// Assumes the bench asks for field on/off; detector output is a level.
`timescale 1ns/1ps

module adc_field_model
(
	input wire logic i_mclk,
	input wire logic i_field_on,
	input wire logic i_carrier_run,
	output logic o_carrier,
	output logic o_ext_field
);
	// ==========================================================
	// Carrier
	// Held high when stopped so driver levels stay predictable
	always_ff @(posedge i_mclk)
	begin
		o_carrier <= i_carrier_run ? ~o_carrier : 1'b1;
	end

	// Remote field, deliberately off the clock grid
	assign #3 o_ext_field = i_field_on;
endmodule

// File: dv/adc_antenna_driver_control_monitor.sv
// Checker on the ports of the antenna driver control block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module adc_antenna_driver_control_monitor
	import adc_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [1:0] i_drv_source_select,
	input wire logic [5:0] i_modulation_depth_setting,
	input wire logic i_soft_power_down,
	input wire logic o_first_antenna_driver_oe,
	input wire logic o_second_antenna_driver_oe,
	input wire logic [5:0] o_mod_depth,
	input wire logic o_field_wake,
	input wire logic [1:0] o_rx_frame_format,
	input wire logic o_collision_avoid_enable,
	input wire logic [1:0] o_slot_n
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	chk_rd_idle:
	assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside read cycle");
	chk_wo_bit:
	assert property (i_rd && i_addr == ADC_OFS_DRV_CTRL
		|=> o_rdata[ADC_B_CHECK] == 1'b0)
		else $error("write-only bit read back");
	chk_depth_src:
	assert property (o_mod_depth == ADC_MOD_DEPTH_FULL
		|| o_mod_depth == $past(i_modulation_depth_setting))
		else $error("depth neither full nor copied");
	chk_oe_first:
	assert property ($past(i_rst_n) |-> o_first_antenna_driver_oe
		== ($past(i_drv_source_select) != ADC_SRC_TRISTATE))
		else $error("first driver enable wrong");
	chk_oe_second:
	assert property ($past(i_rst_n) |-> o_second_antenna_driver_oe
		== ($past(i_drv_source_select) != ADC_SRC_TRISTATE))
		else $error("second driver enable wrong");
	chk_wake_pulse:
	assert property (o_field_wake |-> $past(i_soft_power_down)
		##1 !o_field_wake)
		else $error("wake pulse bad");
	chk_slot_off:
	assert property (!o_collision_avoid_enable |-> o_slot_n == 2'h0)
		else $error("slot set while avoidance off");
	chk_frame_cause:
	assert property ($changed(o_rx_frame_format) |->
		($past(i_wr) && $past(i_addr) == ADC_OFS_RX_MODE)
		|| ($past(i_wr, 2) && $past(i_addr, 2) == ADC_OFS_RX_MODE))
		else $error("framing changed without write");
	chk_ca_cause:
	assert property ($changed(o_collision_avoid_enable) |->
		($past(i_wr) && $past(i_addr) == ADC_OFS_AUTO_CTRL)
		|| ($past(i_wr, 2) && $past(i_addr, 2) == ADC_OFS_AUTO_CTRL))
		else $error("avoidance changed without write");
endmodule

bind adc_antenna_driver_control adc_antenna_driver_control_monitor u_mon (
	.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata),
	.i_drv_source_select(i_drv_source_select),
	.i_modulation_depth_setting(i_modulation_depth_setting),
	.i_soft_power_down(i_soft_power_down),
	.o_first_antenna_driver_oe(o_first_antenna_driver_oe),
	.o_second_antenna_driver_oe(o_second_antenna_driver_oe),
	.o_mod_depth(o_mod_depth), .o_field_wake(o_field_wake),
	.o_rx_frame_format(o_rx_frame_format),
	.o_collision_avoid_enable(o_collision_avoid_enable),
	.o_slot_n(o_slot_n));

// File: dv/adc_antenna_driver_control_tb.sv
// Self-checking bench for the antenna driver control block.
// Assumes the field model supplies carrier and field; short delays.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module adc_antenna_driver_control_tb
	import adc_pkg::*;
;
	logic clk, rst_n, wr, rd, env, sig, last, pd, fon, crun;
	logic [7:0] addr, wdata;
	logic [1:0] sel;
	logic [5:0] depth;
	wire logic car, fld, p1, oe1, p2, oe2, wake, ca;
	wire logic [7:0] rdata;
	wire logic [5:0] mdep;
	wire logic [1:0] frm, slot;
	int fails, n_compared, i, n;

	adc_antenna_driver_control #(.INITIAL_DELAY_TIME_CYCLES(20), .ACTIVE_DELAY_TIME_CYCLES(8),
		.TRFW_CYCLES(4)) uut (.i_mclk(clk), .i_rst_n(rst_n),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_carrier(car), .i_coder_env(env),
		.i_sigin_env(sig), .i_drv_source_select(sel),
		.i_modulation_depth_setting(depth), .i_tx_last_bit_done(last),
		.i_ext_field(fld), .i_soft_power_down(pd),
		.o_first_antenna_driver(p1), .o_first_antenna_driver_oe(oe1),
		.o_second_antenna_driver(p2), .o_second_antenna_driver_oe(oe2),
		.o_mod_depth(mdep), .o_field_wake(wake),
		.o_rx_frame_format(frm), .o_collision_avoid_enable(ca),
		.o_slot_n(slot));
	adc_field_model u_far (.i_mclk(clk), .i_field_on(fon),
		.i_carrier_run(crun), .o_carrier(car), .o_ext_field(fld));

	// ==========================================================
	// Clock and bus tasks
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		rdchk(ADC_OFS_DRV_CTRL, 8'h80);
		rdchk(ADC_OFS_AUTO_CTRL, 8'h00);
		rdchk(ADC_OFS_RX_MODE, 8'h00);
		rdchk(8'h30, 8'h00);
		`CHK({oe1, oe2}, 2'b00)
		for (i = 0; i < 4; i++)
		begin
			wr8(ADC_OFS_RX_MODE, {6'h3F, i[1:0]});
			rdchk(ADC_OFS_RX_MODE, {6'h00, i[1:0]});
			`CHK(frm, i[1:0])
		end
		$display("done t_regs");
	endtask
	// Constant-high source: level set by the enable and inversion bits
	task automatic t_inv;
		sel <= ADC_SRC_HIGH;
		for (i = 0; i < 32; i++)
		begin
			wr8(ADC_OFS_DRV_CTRL, {i[3:0], 2'b00, {2{i[4]}}});
			cyc(2);
			`CHK(p1, i[4] ? ~i[2] : i[0])
			`CHK(p2, i[4] ? ~i[3] : i[1])
		end
		sel <= ADC_SRC_CODER;
		env <= 1'b0;
		wr8(ADC_OFS_DRV_CTRL, 8'h0B);
		cyc(2);
		`CHK(p1, 1'b0)
		`CHK(p2, 1'b1)
		wr8(ADC_OFS_DRV_CTRL, 8'h03);
		cyc(2);
		`CHK(p2, 1'b0)
		env <= 1'b1;
		cyc(2);
		`CHK(p1, 1'b1)
		`CHK(p2, 1'b1)
		// SIGIN envelope takes over from the coder envelope
		sel <= ADC_SRC_SIGIN;
		env <= 1'b0;
		cyc(2);
		`CHK({p1, p2}, 2'b11)
		sig <= 1'b0;
		cyc(2);
		`CHK({p1, p2}, 2'b00)
		`CHK({oe1, oe2}, 2'b11)
		$display("done t_inv");
	endtask
	task automatic t_check;
		wr8(ADC_OFS_DRV_CTRL, 8'h00);
		fon <= 1'b1;
		cyc(6);
		wr8(ADC_OFS_DRV_CTRL, 8'h07);
		rdchk(ADC_OFS_DRV_CTRL, 8'h00);
		wr8(ADC_OFS_DRV_CTRL, 8'h03);
		rdchk(ADC_OFS_DRV_CTRL, 8'h03);
		fon <= 1'b0;
		wr8(ADC_OFS_DRV_CTRL, 8'h00);
		cyc(6);
		$display("done t_check");
	endtask
	task automatic t_auto_bits;
		depth <= 6'h2A;
		wr8(ADC_OFS_AUTO_CTRL, 8'h48);
		cyc(2);
		`CHK(mdep, ADC_MOD_DEPTH_FULL)
		`CHK(ca, 1'b1)
		wr8(ADC_OFS_AUTO_CTRL, 8'h20);
		pd <= 1'b1;
		cyc(2);
		`CHK(mdep, 6'h2A)
		`CHK(slot, 2'h0)
		fon <= 1'b1;
		n = 0;
		repeat (12)
		begin
			@(posedge clk);
			#1 n += (wake === 1'b1);
		end
		`CHK(n, 1)
		fon <= 1'b0;
		pd <= 1'b0;
		wr8(ADC_OFS_AUTO_CTRL, 8'h00);
		cyc(6);
		$display("done t_auto_bits");
	endtask
	// A field blip must restart the field-free wait
	task automatic t_init;
		crun <= 1'b1;
		wr8(ADC_OFS_AUTO_CTRL, 8'h07);
		cyc(10);
		fon <= 1'b1;
		cyc(4);
		fon <= 1'b0;
		cyc(10);
		rdchk(ADC_OFS_DRV_CTRL, 8'h00);
		// Status: initial wait state with the quiet counter running
		rdchk(ADC_OFS_STATUS, 8'h09);
		cyc(20);
		rdchk(ADC_OFS_DRV_CTRL, 8'h03);
		rdchk(ADC_OFS_AUTO_CTRL, 8'h03);
		wr8(ADC_OFS_AUTO_CTRL, 8'h00);
		crun <= 1'b0;
		$display("done t_init");
	endtask
	task automatic t_adt;
		for (i = 1; i < 3; i++)
		begin
			wr8(ADC_OFS_DRV_CTRL, 8'h00);
			wr8(ADC_OFS_AUTO_CTRL, i[7:0]);
			fon <= 1'b1;
			cyc(10);
			fon <= 1'b0;
			cyc(4);
			rdchk(ADC_OFS_DRV_CTRL, 8'h00);
			// Last read before the delay ends, then the first after
			cyc(5);
			rdchk(ADC_OFS_DRV_CTRL, 8'h00);
			rdchk(ADC_OFS_DRV_CTRL, i[7:0]);
		end
		wr8(ADC_OFS_AUTO_CTRL, 8'h80);
		last <= 1'b1;
		@(posedge clk);
		last <= 1'b0;
		cyc(2);
		rdchk(ADC_OFS_DRV_CTRL, 8'h00);
		$display("done t_adt");
	endtask
	// Response avoidance stretches the active delay by n slots
	task automatic t_ca;
		wr8(ADC_OFS_AUTO_CTRL, 8'h09);
		fon <= 1'b1;
		cyc(10);
		fon <= 1'b0;
		cyc(4);
		rdchk(ADC_OFS_DRV_CTRL, 8'h00);
		cyc(1);
		`CHK(ca, 1'b1)
		n = slot;
		cyc(4 + 4 * n);
		rdchk(ADC_OFS_DRV_CTRL, 8'h00);
		rdchk(ADC_OFS_DRV_CTRL, 8'h01);
		wr8(ADC_OFS_AUTO_CTRL, 8'h00);
		cyc(2);
		`CHK(ca, 1'b0)
		`CHK(slot, 2'h0)
		$display("done t_ca");
	endtask

	// ==========================================================
	// Verdict and sequence
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		fails = 0;
		n_compared = 0;
		rst_n = 1'b0;
		{wr, rd, env, last, pd, fon, crun} = 7'h00;
		sig = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		sel = ADC_SRC_TRISTATE;
		depth = 6'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_inv();
		t_check();
		t_auto_bits();
		t_init();
		t_adt();
		t_ca();
		results();
	end
	// Tests take about 400 cycles; a hang is cut well after that
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end
endmodule
